/* File: src/scs_cfg.svh */
// Constants for the system clock source select block.
// Overview of operation
// - Eight clock modes chosen by oscillator mode field.
// - External clock codes 111, 110, 101 set power.
// - External clock mode skips the crystal start-up timer.
// - Static logic: stopped clock halts, state is kept.
// - External clock mode clocks from the input pin.
// - External clock mode: output pin is I/O or clock.
// - Oscillator mode field gives default clock after reset.
// - Select field switches to secondary or internal source.
// - Internal block offers 16 MHz, 500 kHz, 31 kHz.
// - Internal mode spans 31 kHz up to 32 MHz.
// - Fail monitor detects lost external clock, picks internal.
// - Crystal modes select low, medium or high gain.
// - Codes 100 internal, 011 RC, 010/001/000 crystals.
// - Crystal modes ignore clock out; else clear bit routes.
// - Crystal modes count 1024 cycles before execution.
// - Select field upper bit one picks internal block.
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
`define SCS_MODE_LP 3'h0
`define SCS_MODE_XT 3'h1
`define SCS_MODE_HS 3'h2
`define SCS_MODE_RC 3'h3
`define SCS_MODE_INT 3'h4
`define SCS_MODE_ECL 3'h5
`define SCS_MODE_ECM 3'h6
`define SCS_MODE_ECH 3'h7
`define SCS_GAIN_LOW 2'h0
`define SCS_GAIN_MID 2'h1
`define SCS_GAIN_HIGH 2'h2
`define SCS_PWR_LOW 2'h0
`define SCS_PWR_MID 2'h1
`define SCS_PWR_HIGH 2'h2
`define SCS_IFREQ_SLOW 2'h0
`define SCS_IFREQ_MID 2'h1
`define SCS_IFREQ_FAST 2'h2
`define SCS_IFREQ_PLL 2'h3
`define SCS_OST_LAST 10'h03FF
`define SCS_CLK_MHZ 250
`define SCS_FAIL_TIME_NS 100000
`define SCS_FAIL_CYCLES (`SCS_FAIL_TIME_NS * `SCS_CLK_MHZ / 1000)
`define SCS_FAIL_W 16
`define SCS_ADDR_CTRL 12'h000
`define SCS_ADDR_STAT 12'h004
`define SCS_ADDR_ISTAT 12'h008
`define SCS_ADDR_IMASK 12'h00C
`define SCS_CTRL_RST 4'h8
`define SCS_IMASK_RST 3'h0
`define SCS_EV_FAIL 0
`define SCS_EV_OST 1
`define SCS_EV_SWITCH 2
`endif

/* File: src/scs_pkg.sv */
// Types shared by the system clock source select block.
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_SRC_EXT,
    SCS_SRC_T1,
    SCS_SRC_INT
  } scs_src_t;
endpackage : scs_pkg

/* File: src/scs_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module scs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : scs_sync

/* File: src/scs_top.sv */
// System clock source selection, start-up timing and fail-safe switch.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "scs_cfg.svh"
module scs_top #(
  parameter int FAIL_CYCLES = `SCS_FAIL_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [2:0] osc_mode_cfg_in,
  input wire logic clock_out_disable_in,
  input wire logic fail_monitor_en_in,
  input wire logic osc_in_pin_in,
  input wire logic t1_osc_in,
  input wire logic fast_internal_osc_in,
  input wire logic mid_internal_osc_in,
  input wire logic slow_internal_osc_in,
  input wire logic fast_osc_pll_in,
  input wire logic power_up_timer_done_in,
  input wire logic wake_in,
  input wire logic gpio_out_in,
  input wire logic gpio_oe_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic sysclk_out,
  output logic core_run_out,
  output scs_pkg::scs_src_t cur_src_out,
  output logic [1:0] amp_gain_out,
  output logic [1:0] ext_power_out,
  output logic osc_out_pin_out,
  output logic osc_out_pin_oe_out,
  output logic irq_out
);
  import scs_pkg::*;

  logic [5:0] pin_s;
  logic ext_s;
  logic t1_s;
  logic int_s;
  logic ext_prev_r;
  logic ext_rise;
  logic [2:0] mode_r;
  logic xtal_mode;
  logic ec_mode;
  logic [1:0] select_r;
  logic [1:0] ifreq_r;
  logic [2:0] imask_r;
  logic [2:0] istat_r;
  logic [2:0] ev;
  logic fail_prev_r;
  logic ost_prev_r;
  scs_src_t src_prev_r;
  logic [9:0] ost_cnt_r;
  logic ost_done_r;
  logic fail_r;
  logic [`SCS_FAIL_W-1:0] fail_cnt_r;
  scs_src_t cur_src_r;
  scs_src_t target;
  logic new_level;
  logic sysclk_r;
  logic pready_r;
  logic access;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_data;

  // The source pins come from other clock domains.
  scs_sync #(
    .WIDTH(6)
  ) u_pin_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .async_in({fast_osc_pll_in, slow_internal_osc_in, mid_internal_osc_in,
      fast_internal_osc_in, t1_osc_in, osc_in_pin_in}),
    .sync_out(pin_s)
  );

  assign ext_s = pin_s[0];
  assign t1_s = pin_s[1];

  // The internal block offers its three oscillators plus the PLL output.
  always_comb
  begin
    case (ifreq_r)
      `SCS_IFREQ_SLOW: int_s = pin_s[4];
      `SCS_IFREQ_MID: int_s = pin_s[3];
      `SCS_IFREQ_FAST: int_s = pin_s[2];
      default: int_s = pin_s[5];
    endcase
  end

  // Mode is captured while reset is held and frozen afterwards.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      mode_r <= osc_mode_cfg_in;
  end

  assign xtal_mode = (mode_r == `SCS_MODE_LP) || (mode_r == `SCS_MODE_XT) ||
    (mode_r == `SCS_MODE_HS);
  assign ec_mode = (mode_r == `SCS_MODE_ECL) || (mode_r == `SCS_MODE_ECM) ||
    (mode_r == `SCS_MODE_ECH);

  always_comb
  begin
    case (mode_r)
      `SCS_MODE_XT: amp_gain_out = `SCS_GAIN_MID;
      `SCS_MODE_HS: amp_gain_out = `SCS_GAIN_HIGH;
      default: amp_gain_out = `SCS_GAIN_LOW;
    endcase
  end

  always_comb
  begin
    case (mode_r)
      `SCS_MODE_ECH: ext_power_out = `SCS_PWR_HIGH;
      `SCS_MODE_ECM: ext_power_out = `SCS_PWR_MID;
      default: ext_power_out = `SCS_PWR_LOW;
    endcase
  end

  // Last cycle's copies give the edges of the pin and of the flags.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      ext_prev_r <= 1'b0;
      fail_prev_r <= 1'b0;
      ost_prev_r <= 1'b0;
      src_prev_r <= SCS_SRC_EXT;
    end
    else
    begin
      ext_prev_r <= ext_s;
      fail_prev_r <= fail_r;
      ost_prev_r <= ost_done_r;
      src_prev_r <= cur_src_r;
    end
  end

  assign ext_rise = ext_s && !ext_prev_r;

  // Start-up timer restarts on wake and waits for the power-up timer.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in || wake_in)
    begin
      ost_cnt_r <= '0;
      ost_done_r <= 1'b0;
    end
    else if (!xtal_mode)
      ost_done_r <= 1'b1;
    else if (!ost_done_r && power_up_timer_done_in && ext_rise)
    begin
      ost_cnt_r <= ost_cnt_r + 10'h001;
      if (ost_cnt_r == `SCS_OST_LAST)
        ost_done_r <= 1'b1;
    end
  end

  assign core_run_out = ost_done_r;

  // A stopped external clock is only a fault when the monitor is on;
  // otherwise the core simply halts with its state intact.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      fail_cnt_r <= '0;
      fail_r <= 1'b0;
    end
    else if (!fail_monitor_en_in || cur_src_r != SCS_SRC_EXT ||
      mode_r == `SCS_MODE_INT || !ost_done_r || ext_s != ext_prev_r)
      fail_cnt_r <= '0;
    else if (fail_cnt_r == `SCS_FAIL_W'(FAIL_CYCLES - 1))
      fail_r <= 1'b1;
    else
      fail_cnt_r <= fail_cnt_r + 1'b1;
  end

  always_comb
  begin
    if (fail_r || select_r[1])
      target = SCS_SRC_INT;
    else if (select_r == 2'h1)
      target = SCS_SRC_T1;
    else if (mode_r == `SCS_MODE_INT)
      target = SCS_SRC_INT;
    else if (ost_done_r)
      target = SCS_SRC_EXT;
    else
      target = cur_src_r;
  end

  always_comb
  begin
    case (target)
      SCS_SRC_EXT: new_level = ext_s;
      SCS_SRC_T1: new_level = t1_s;
      default: new_level = int_s;
    endcase
  end

  // The source changes only while both the output and the new source
  // are low, so neither phase can be cut short.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      cur_src_r <= SCS_SRC_EXT;
    else if (target != cur_src_r && !sysclk_r && !new_level)
      cur_src_r <= target;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      sysclk_r <= 1'b0;
    else if (target != cur_src_r)
      sysclk_r <= sysclk_r && new_level;
    else
    begin
      case (cur_src_r)
        SCS_SRC_EXT: sysclk_r <= ext_s;
        SCS_SRC_T1: sysclk_r <= t1_s;
        default: sysclk_r <= int_s;
      endcase
    end
  end

  assign sysclk_out = sysclk_r;
  assign cur_src_out = cur_src_r;

  // Crystal modes leave the pin to the amplifier, so it is never driven.
  always_comb
  begin
    if (xtal_mode)
    begin
      osc_out_pin_out = 1'b0;
      osc_out_pin_oe_out = 1'b0;
    end
    else if (!clock_out_disable_in)
    begin
      osc_out_pin_out = sysclk_r;
      osc_out_pin_oe_out = 1'b1;
    end
    else
    begin
      osc_out_pin_out = gpio_out_in;
      osc_out_pin_oe_out = gpio_oe_in;
    end
  end

  // One wait state lets read data come from a flip-flop.
  assign access = psel_in && penable_in;
  assign wr_en = access && pready_r && pwrite_in;
  assign mapped = (paddr_in == `SCS_ADDR_CTRL) ||
    (paddr_in == `SCS_ADDR_STAT) || (paddr_in == `SCS_ADDR_ISTAT) ||
    (paddr_in == `SCS_ADDR_IMASK);

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      pready_r <= 1'b0;
    else
      pready_r <= access && !pready_r;
  end

  assign pready_out = pready_r;
  assign pslverr_out = pready_r && !mapped;

  always_comb
  begin
    case (paddr_in)
      `SCS_ADDR_CTRL: rd_data = {28'h000_0000, ifreq_r, select_r};
      `SCS_ADDR_STAT: rd_data = {24'h00_0000, mode_r,
        (target != cur_src_r), fail_r, ost_done_r, cur_src_r};
      `SCS_ADDR_ISTAT: rd_data = {29'h0000_0000, istat_r};
      `SCS_ADDR_IMASK: rd_data = {29'h0000_0000, imask_r};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      prdata_out <= 32'h0000_0000;
    else if (access && !pready_r && !pwrite_in)
      prdata_out <= rd_data;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      {ifreq_r, select_r} <= `SCS_CTRL_RST;
      imask_r <= `SCS_IMASK_RST;
    end
    else if (wr_en && paddr_in == `SCS_ADDR_CTRL)
    begin
      select_r <= pwdata_in[1:0];
      ifreq_r <= pwdata_in[3:2];
    end
    else if (wr_en && paddr_in == `SCS_ADDR_IMASK)
      imask_r <= pwdata_in[2:0];
  end

  assign ev[`SCS_EV_FAIL] = fail_r && !fail_prev_r;
  assign ev[`SCS_EV_OST] = ost_done_r && !ost_prev_r;
  assign ev[`SCS_EV_SWITCH] = cur_src_r != src_prev_r;

  // A new event beats a write-one-to-clear in the same cycle.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      istat_r <= 3'h0;
    else if (wr_en && paddr_in == `SCS_ADDR_ISTAT)
      istat_r <= (istat_r & ~pwdata_in[2:0]) | ev;
    else
      istat_r <= istat_r | ev;
  end

  assign irq_out = |(istat_r & imask_r);

  a_mode_frozen: assert property (@(posedge mclk_in) disable iff (rst_in)
    !$past(rst_in) |-> $stable(mode_r))
    else $error("oscillator mode changed outside reset");
  a_ec_no_ost: assert property (@(posedge mclk_in) disable iff (rst_in)
    ec_mode && !$past(rst_in) && !$past(wake_in) |-> core_run_out)
    else $error("external clock mode delayed execution");
  a_ost_count: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(ost_done_r) && xtal_mode |->
    $past(ost_cnt_r) == `SCS_OST_LAST && $past(ext_rise))
    else $error("start-up timer ended before its count");
  a_xtal_gain: assert property (@(posedge mclk_in) disable iff (rst_in)
    xtal_mode |-> amp_gain_out == mode_r[1:0])
    else $error("crystal gain does not follow the mode");
  a_xtal_pin_free: assert property (@(posedge mclk_in) disable iff (rst_in)
    xtal_mode |-> !osc_out_pin_oe_out)
    else $error("output pin driven in a crystal mode");
  a_switch_low: assert property (@(posedge mclk_in) disable iff (rst_in)
    cur_src_r != $past(cur_src_r) |-> !sysclk_r && !$past(sysclk_r))
    else $error("source changed while the clock was high");
  a_fail_to_int: assert property (@(posedge mclk_in) disable iff (rst_in)
    fail_r |-> target == SCS_SRC_INT)
    else $error("clock failure did not select internal source");
  a_select_int: assert property (@(posedge mclk_in) disable iff (rst_in)
    select_r[1] && !$past(rst_in) |->
    cur_src_r == SCS_SRC_INT || target == SCS_SRC_INT)
    else $error("upper select bit did not pick internal source");
  a_run_gate: assert property (@(posedge mclk_in) disable iff (rst_in)
    xtal_mode && $fell(ost_done_r) |-> !core_run_out [*2])
    else $error("execution ran before start-up timer ended");
  a_irq_level: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(istat_r[`SCS_EV_FAIL]) && imask_r[`SCS_EV_FAIL] |-> irq_out)
    else $error("unmasked event raised no interrupt");

  c_fail_switch: cover property (@(posedge mclk_in) disable iff (rst_in)
    fail_r && cur_src_r == SCS_SRC_INT);
  c_t1_select: cover property (@(posedge mclk_in) disable iff (rst_in)
    cur_src_r == SCS_SRC_T1);
  c_ost_done: cover property (@(posedge mclk_in) disable iff (rst_in)
    xtal_mode && $rose(ost_done_r));
  c_irq: cover property (@(posedge mclk_in) disable iff (rst_in)
    $rose(irq_out));
endmodule : scs_top

/* File: dv/scs_osc_model.sv */
// Behavioural model of the external, secondary and internal sources.
`timescale 1ns/1ps
module scs_osc_model (
  input wire logic ext_run_in,
  output logic ext_clk_out,
  output logic t1_clk_out,
  output logic fast_clk_out,
  output logic mid_clk_out,
  output logic slow_clk_out,
  output logic pll_clk_out
);
  initial
  begin
    ext_clk_out = 1'h0;
    t1_clk_out = 1'h0;
    fast_clk_out = 1'h0;
    mid_clk_out = 1'h0;
    slow_clk_out = 1'h0;
    pll_clk_out = 1'h0;
  end
  // Periods are shrunk so the two-stage synchroniser still sees each level.
  // A stopped external source parks low, as a dead crystal would.
  always #8 ext_clk_out = ext_run_in ? ~ext_clk_out : 1'h0;
  always #20 t1_clk_out = ~t1_clk_out;
  always #6 fast_clk_out = ~fast_clk_out;
  always #10 mid_clk_out = ~mid_clk_out;
  always #14 slow_clk_out = ~slow_clk_out;
  always #5 pll_clk_out = ~pll_clk_out;
endmodule : scs_osc_model

/* File: dv/scs_top_test.sv */
// Self-checking testbench for the clock source select block.
`timescale 1ns/1ps
module scs_top_test;
  import scs_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ext_run = 1'h1;
  logic [2:0] mode = 3'h7;
  logic cod = 1'h0;
  logic fen = 1'h1;
  logic put = 1'h1;
  logic wake = 1'h0;
  logic gpio = 1'h0;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, sysclk, run, oe, pin, irq, err;
  logic ext, t1, fst, mid, slw, pll;
  logic [1:0] gain, plvl;
  scs_src_t src;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  scs_top #(.FAIL_CYCLES(64)) DUT (
    .mclk_in(clk), .rst_in(rst), .osc_mode_cfg_in(mode),
    .clock_out_disable_in(cod), .fail_monitor_en_in(fen),
    .osc_in_pin_in(ext), .t1_osc_in(t1), .fast_internal_osc_in(fst),
    .mid_internal_osc_in(mid), .slow_internal_osc_in(slw),
    .fast_osc_pll_in(pll), .power_up_timer_done_in(put),
    .wake_in(wake), .gpio_out_in(gpio), .gpio_oe_in(gpio),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .sysclk_out(sysclk),
    .core_run_out(run), .cur_src_out(src), .amp_gain_out(gain),
    .ext_power_out(plvl), .osc_out_pin_out(pin),
    .osc_out_pin_oe_out(oe), .irq_out(irq)
  );
  scs_osc_model osc (
    .ext_run_in(ext_run), .ext_clk_out(ext), .t1_clk_out(t1),
    .fast_clk_out(fst), .mid_clk_out(mid), .slow_clk_out(slw),
    .pll_clk_out(pll)
  );
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // The request is held until the edge that samples pready high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    check(32'(pready), 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask : apb
  task wait_src(input scs_src_t e);
    int n;
    n = 0;
    while (src !== e && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(src), 32'(e));
  endtask : wait_src
  task do_reset(input logic [2:0] m, input logic c);
    @(posedge clk);
    mode <= m;
    cod <= c;
    rst <= 1'h1;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
  endtask : do_reset
  task t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = 3'(i);
      gpio <= m[1];
      do_reset(m, m[0]);
      mode <= ~m;
      repeat (4) @(posedge clk);
      check(32'(gain), m < 3'h3 ? 32'(m) : 32'h0000_0000);
      check(32'(plvl), m == 3'h7 ? 32'h2 : 32'(m == 3'h6));
      check(32'(oe), 32'(m > 3'h2 && (!m[0] || m[1])));
      if (m < 3'h3 || m[0])
        check(32'(pin), 32'(m > 3'h2 && m[1]));
      else
        check(32'(pin), 32'(sysclk));
      check(32'(run), 32'(m > 3'h2));
      wait_src(m == 3'h4 ? SCS_SRC_INT : SCS_SRC_EXT);
      apb(1'h0, 12'h004, 32'h0000_0000);
      check(32'(rd[7:5]), 32'(m));
    end
    $display("t_modes done");
  endtask : t_modes
  task t_ost();
    put <= 1'h0;
    do_reset(3'h2, 1'h0);
    repeat (300) @(posedge ext);
    @(posedge clk);
    put <= 1'h1;
    repeat (1000) @(posedge ext);
    check(32'(run), 32'h0000_0000);
    repeat (40) @(posedge ext);
    check(32'(run), 32'h0000_0001);
    apb(1'h0, 12'h008, 32'h0000_0000);
    check(32'(rd[1]), 32'h0000_0001);
    @(posedge clk);
    wake <= 1'h1;
    @(posedge clk);
    wake <= 1'h0;
    repeat (3) @(posedge clk);
    check(32'(run), 32'h0000_0000);
    repeat (1040) @(posedge ext);
    check(32'(run), 32'h0000_0001);
    $display("t_ost done");
  endtask : t_ost
  task t_switch();
    logic [1:0] sels [4];
    scs_src_t exps [4];
    sels = '{2'h2, 2'h1, 2'h3, 2'h0};
    exps = '{SCS_SRC_INT, SCS_SRC_T1, SCS_SRC_INT, SCS_SRC_EXT};
    do_reset(3'h7, 1'h0);
    apb(1'h0, 12'h000, 32'h0000_0000);
    check(rd, 32'h0000_0008);
    apb(1'h0, 12'h00C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'h1, 12'h008, 32'h0000_0007);
    apb(1'h1, 12'h00C, 32'h0000_0004);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, 12'h000, {28'h000_0002, sels[i]});
      wait_src(exps[i]);
      repeat (3) @(posedge clk);
      check(32'(irq), 32'h0000_0001);
      apb(1'h1, 12'h008, 32'h0000_0004);
      @(posedge clk);
      check(32'(irq), 32'h0000_0000);
    end
    apb(1'h1, 12'h010, 32'hFFFF_FFFF);
    check(32'(err), 32'h0000_0001);
    apb(1'h0, 12'h010, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    $display("t_switch done");
  endtask : t_switch
  task t_fail();
    int n;
    do_reset(3'h5, 1'h0);
    fen <= 1'h0;
    ext_run <= 1'h0;
    repeat (200) @(posedge clk);
    check(32'(src), 32'(SCS_SRC_EXT));
    check(32'(sysclk), 32'h0000_0000);
    check(32'(run), 32'h0000_0001);
    ext_run <= 1'h1;
    n = 0;
    while (sysclk !== 1'h1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(sysclk), 32'h0000_0001);
    fen <= 1'h1;
    apb(1'h1, 12'h00C, 32'h0000_0001);
    @(posedge clk);
    ext_run <= 1'h0;
    wait_src(SCS_SRC_INT);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h0000_0001);
    apb(1'h0, 12'h004, 32'h0000_0000);
    check(32'(rd[3]), 32'h0000_0001);
    apb(1'h1, 12'h000, 32'h0000_0008);
    repeat (20) @(posedge clk);
    check(32'(src), 32'(SCS_SRC_INT));
    ext_run <= 1'h1;
    $display("t_fail done");
  endtask : t_fail
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    t_modes();
    t_ost();
    t_switch();
    t_fail();
    print_verdict();
  end
endmodule : scs_top_test
